// ---- design/cadence_lock_tracker.sv ----
/*
  Field-rate lock tracker: a confidence counter that rises on fields that
  show the cadence and falls on fields that break it.
  Assumes field_done is a one-cycle pulse per field.
*/
`timescale 1ns/1ps
module cadence_lock_tracker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic field_done,
  input wire logic evidence,
  input wire logic [7:0] lock_thresh,
  input wire logic [7:0] unlock_thresh,
  output logic locked
);
  cadence_tuning_pkg::lock_state_type state_reg;
  logic [7:0] conf_reg;
  logic [7:0] conf_next;

  always_comb begin
    conf_next = conf_reg;
    if (evidence && conf_reg != 8'hff) begin
      conf_next = conf_reg + 8'h01;
    end else if (!evidence && conf_reg != 8'h00) begin
      conf_next = conf_reg - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conf_reg <= 8'h00;
      state_reg <= cadence_tuning_pkg::LOCK_IDLE;
    end else if (!enable) begin
      conf_reg <= 8'h00;
      state_reg <= cadence_tuning_pkg::LOCK_IDLE;
    end else if (field_done) begin
      conf_reg <= conf_next;
      case (state_reg)
        cadence_tuning_pkg::LOCK_IDLE: begin
          // A higher lock threshold demands more agreeing fields
          if (conf_next >= lock_thresh) begin
            state_reg <= cadence_tuning_pkg::LOCK_HELD;
          end
        end
        cadence_tuning_pkg::LOCK_HELD: begin
          // Unlock close to lock means a short run of misses drops it
          if (conf_next < unlock_thresh) begin
            state_reg <= cadence_tuning_pkg::LOCK_IDLE;
          end
        end
        default: state_reg <= cadence_tuning_pkg::LOCK_IDLE;
      endcase
    end
  end

  assign locked = state_reg == cadence_tuning_pkg::LOCK_HELD;
endmodule // cadence_lock_tracker

// ---- design/cadence_motion_tuning_regs.sv ----
/*
  Cadence and motion tuning register bank with its field-rate cadence
  evidence, lock trackers and per-pixel bob/weave and debug overlay.
  Assumes an AHB-Lite master with single word transfers and a video
  front end that pulses field_start, line_valid and pixel_valid.
*/
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/1ps
module cadence_motion_tuning_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic field_start,
  input wire logic [10:0] field_lines,
  input wire logic line_valid,
  input wire logic [15:0] line_diff_raw,
  input wire logic [7:0] line_comb_score,
  input wire logic pixel_valid,
  input wire logic [15:0] pixel_sad_raw,
  input wire logic [7:0] pixel_y,
  input wire logic [7:0] pixel_cb,
  input wire logic [7:0] pixel_cr,
  output logic out_valid,
  output logic [7:0] out_y,
  output logic [7:0] out_cb,
  output logic [7:0] out_cr,
  output logic out_weave,
  output logic pulldown_locked,
  output logic pair_locked,
  output logic running
);
  // Register storage
  logic go_reg;
  logic run_reg;
  logic [7:0] diff_count_reg;
  logic [7:0] pd_lock_reg;
  logic [7:0] pd_unlock_reg;
  logic [7:0] diff_thresh_reg;
  logic [7:0] line_ratio_reg;
  logic [7:0] noise_shift_reg;
  logic [3:0] pair_lock_reg;
  logic [3:0] pair_unlock_reg;
  logic [7:0] comb_thresh_reg;
  logic [7:0] motion_shift_reg;
  logic [2:0] debug_reg;
  logic cadence_on_reg;

  // Bus data phase state
  logic wr_pending_reg;
  logic [4:0] wr_index_reg;
  logic addr_ok_reg;
  logic take;
  logic [4:0] a_index;
  logic a_ok;
  logic [31:0] rd_value;

  // Field-rate cadence state
  logic in_field_reg;
  logic [10:0] line_diff_acc_reg;
  logic [10:0] comb_acc_reg;
  logic [2:0] phase_reg;
  logic prev_comb_reg;
  logic field_done;
  logic diff_hit;
  logic comb_hit;
  logic [10:0] needed_lines;
  logic [10:0] still_lines;
  logic repeat_field;
  logic comb_field;
  logic pd_evidence;
  logic pair_evidence;

  // Pixel path
  logic [15:0] motion_scaled;
  logic [7:0] motion_level;

  // Zero wait states: every register answers in the data phase, so the
  // bank never stretches a transfer and never signals an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && htrans[1] && hready;
  // Index from the word address; the upper bits are checked by a_ok
  assign a_index = haddr[cadence_tuning_pkg::ADDR_LSB +: 5];
  // Anything outside the word-aligned map reads zero and is not stored
  assign a_ok = (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'b00);

  // Narrow fields sit in the low bits; everything above reads zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (a_index)
      cadence_tuning_pkg::IDX_CONTROL: rd_value = {31'h0, go_reg};
      cadence_tuning_pkg::IDX_STATUS: rd_value = {31'h0, run_reg};
      cadence_tuning_pkg::IDX_DIFF_COUNT: rd_value = {24'h0, diff_count_reg};
      cadence_tuning_pkg::IDX_PD_LOCK: rd_value = {24'h0, pd_lock_reg};
      cadence_tuning_pkg::IDX_PD_UNLOCK: rd_value = {24'h0, pd_unlock_reg};
      cadence_tuning_pkg::IDX_DIFF_THRESH: rd_value = {24'h0, diff_thresh_reg};
      cadence_tuning_pkg::IDX_LINE_RATIO: rd_value = {24'h0, line_ratio_reg};
      cadence_tuning_pkg::IDX_NOISE_SHIFT: rd_value = {24'h0, noise_shift_reg};
      cadence_tuning_pkg::IDX_PAIR_LOCK: rd_value = {28'h0, pair_lock_reg};
      cadence_tuning_pkg::IDX_PAIR_UNLOCK: rd_value = {28'h0, pair_unlock_reg};
      cadence_tuning_pkg::IDX_COMB_THRESH: rd_value = {24'h0, comb_thresh_reg};
      cadence_tuning_pkg::IDX_MOTION_SHIFT: rd_value = {24'h0, motion_shift_reg};
      cadence_tuning_pkg::IDX_DEBUG: rd_value = {29'h0, debug_reg};
      cadence_tuning_pkg::IDX_CADENCE_CFG: rd_value = {31'h0, cadence_on_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= a_ok ? rd_value : 32'h0000_0000;
    end
  end

  // Address phase held for the write that lands one cycle later; it is
  // refreshed on every ready cycle so a stale write can never replay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_index_reg <= 5'h00;
      addr_ok_reg <= 1'b0;
    end else if (hready) begin
      wr_pending_reg <= take && hwrite;
      wr_index_reg <= a_index;
      addr_ok_reg <= a_ok;
    end
  end

  // Register writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_reg <= 1'b0;
      pd_lock_reg <= cadence_tuning_pkg::RST_PD_LOCK;
      pd_unlock_reg <= cadence_tuning_pkg::RST_PD_UNLOCK;
      diff_thresh_reg <= cadence_tuning_pkg::RST_DIFF_THRESH;
      line_ratio_reg <= cadence_tuning_pkg::RST_LINE_RATIO;
      noise_shift_reg <= cadence_tuning_pkg::RST_NOISE_SHIFT;
      pair_lock_reg <= cadence_tuning_pkg::RST_PAIR_LOCK;
      pair_unlock_reg <= cadence_tuning_pkg::RST_PAIR_UNLOCK;
      comb_thresh_reg <= cadence_tuning_pkg::RST_COMB_THRESH;
      motion_shift_reg <= cadence_tuning_pkg::RST_MOTION_SHIFT;
      debug_reg <= cadence_tuning_pkg::RST_DEBUG;
      cadence_on_reg <= cadence_tuning_pkg::RST_CADENCE_ON;
    end else if (wr_pending_reg && addr_ok_reg) begin
      // Indices 13, 15 and every read-only index fall to the default
      case (wr_index_reg)
        cadence_tuning_pkg::IDX_CONTROL: go_reg <= hwdata[0];
        cadence_tuning_pkg::IDX_PD_LOCK: pd_lock_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_PD_UNLOCK: pd_unlock_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_DIFF_THRESH: diff_thresh_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_LINE_RATIO: line_ratio_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_NOISE_SHIFT: noise_shift_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_PAIR_LOCK: pair_lock_reg <= hwdata[3:0];
        cadence_tuning_pkg::IDX_PAIR_UNLOCK: pair_unlock_reg <= hwdata[3:0];
        cadence_tuning_pkg::IDX_COMB_THRESH: comb_thresh_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_MOTION_SHIFT: motion_shift_reg <= hwdata[7:0];
        cadence_tuning_pkg::IDX_DEBUG: debug_reg <= hwdata[2:0];
        cadence_tuning_pkg::IDX_CADENCE_CFG: cadence_on_reg <= hwdata[0];
        default: go_reg <= go_reg;
      endcase
    end
  end

  // Go is sampled only where control is read, at the field boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
    end else if (field_start) begin
      run_reg <= go_reg;
    end
  end

  assign running = run_reg;

  line_classifier classify (
    .diff_raw(line_diff_raw),
    .comb_score(line_comb_score),
    .motion_shift(motion_shift_reg),
    .noise_shift(noise_shift_reg),
    .diff_thresh(diff_thresh_reg),
    .comb_thresh(comb_thresh_reg),
    .diff_hit(diff_hit),
    .comb_hit(comb_hit)
  );

  // A field closes when the next one starts; the first start closes nothing
  assign field_done = field_start && in_field_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_field_reg <= 1'b0;
    end else if (field_start) begin
      in_field_reg <= go_reg;
    end
  end

  // Counts saturate at 11'h7ff instead of wrapping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_diff_acc_reg <= 11'h000;
      comb_acc_reg <= 11'h000;
    end else if (field_start) begin
      line_diff_acc_reg <= 11'h000;
      comb_acc_reg <= 11'h000;
    end else if (line_valid && run_reg) begin
      if (diff_hit && line_diff_acc_reg != 11'h7ff) begin
        line_diff_acc_reg <= line_diff_acc_reg + 11'h001;
      end
      if (comb_hit && comb_acc_reg != 11'h7ff) begin
        comb_acc_reg <= comb_acc_reg + 11'h001;
      end
    end
  end

  // Snapshot once per field, saturated to the register width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diff_count_reg <= 8'h00;
    end else if (field_done) begin
      diff_count_reg <= (line_diff_acc_reg[10:8] != 3'h0) ? 8'hff :
        line_diff_acc_reg[7:0];
    end
  end

  // A ratio of 11 or more needs no lines at all, so every field then
  // counts as a repeat; software should keep the ratio small
  always_comb begin
    needed_lines = field_lines >> line_ratio_reg;
    still_lines = (field_lines > line_diff_acc_reg) ?
      field_lines - line_diff_acc_reg : 11'h000;
    repeat_field = still_lines >= needed_lines;
    comb_field = comb_acc_reg >= needed_lines;
    // A 3:2 repeat belongs exactly on the fifth field of the period
    pd_evidence = repeat_field == (phase_reg == cadence_tuning_pkg::PULLDOWN_PERIOD_LAST);
    // 2:2 content alternates combed and clean fields
    pair_evidence = comb_field != prev_comb_reg;
  end

  // A repeat field resynchronises the five-field phase to the film
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 3'h0;
      prev_comb_reg <= 1'b0;
    end else if (field_done) begin
      prev_comb_reg <= comb_field;
      if (repeat_field || phase_reg == cadence_tuning_pkg::PULLDOWN_PERIOD_LAST) begin
        phase_reg <= 3'h0;
      end else begin
        phase_reg <= phase_reg + 3'h1;
      end
    end
  end

  // One tracker design serves both cadences; the 4-bit 2:2 thresholds
  // are zero-extended so they compare on the same 8-bit scale
  cadence_lock_tracker pulldown_track (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(cadence_on_reg),
    .field_done(field_done),
    .evidence(pd_evidence),
    .lock_thresh(pd_lock_reg),
    .unlock_thresh(pd_unlock_reg),
    .locked(pulldown_locked)
  );

  cadence_lock_tracker pair_track (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(cadence_on_reg),
    .field_done(field_done),
    .evidence(pair_evidence),
    .lock_thresh({4'h0, pair_lock_reg}),
    .unlock_thresh({4'h0, pair_unlock_reg}),
    .locked(pair_locked)
  );

  // Saturate rather than wrap so heavy motion never reads as still
  always_comb begin
    motion_scaled = pixel_sad_raw >> motion_shift_reg;
    motion_level = (motion_scaled[15:8] != 8'h00) ? 8'hff : motion_scaled[7:0];
  end

  // One pipeline stage; bob-only wins when both force bits are set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_y <= 8'h00;
      out_cb <= 8'h00;
      out_cr <= 8'h00;
      out_weave <= 1'b0;
    end else begin
      out_valid <= pixel_valid && run_reg;
      if (pixel_valid) begin
        if (debug_reg[cadence_tuning_pkg::DBG_BOB_ONLY]) begin
          out_weave <= 1'b0;
        end else if (debug_reg[cadence_tuning_pkg::DBG_WEAVE_ONLY]) begin
          out_weave <= 1'b1;
        end else begin
          out_weave <= (motion_level == 8'h00) || pulldown_locked || pair_locked;
        end
        if (debug_reg[cadence_tuning_pkg::DBG_VISUALIZE] && motion_level != 8'h00) begin
          out_y <= motion_level;
          out_cb <= cadence_tuning_pkg::PINK_CHROMA;
          out_cr <= cadence_tuning_pkg::PINK_CHROMA;
        end else begin
          out_y <= pixel_y;
          out_cb <= pixel_cb;
          out_cr <= pixel_cr;
        end
      end
    end
  end
endmodule // cadence_motion_tuning_regs

// ---- design/cadence_tuning_pkg.sv ----
/*
  Shared constants for the cadence and motion tuning register bank:
  register indices, reset values and field positions.
  Assumes word-aligned AHB-Lite access, byte address = index * 4.
*/
package cadence_tuning_pkg;
  localparam int unsigned ADDR_LSB = 2;
  localparam logic [4:0] IDX_CONTROL = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_DIFF_COUNT = 5'h04;
  localparam logic [4:0] IDX_PD_LOCK = 5'h05;
  localparam logic [4:0] IDX_PD_UNLOCK = 5'h06;
  localparam logic [4:0] IDX_DIFF_THRESH = 5'h07;
  localparam logic [4:0] IDX_LINE_RATIO = 5'h08;
  localparam logic [4:0] IDX_NOISE_SHIFT = 5'h09;
  localparam logic [4:0] IDX_PAIR_LOCK = 5'h0a;
  localparam logic [4:0] IDX_PAIR_UNLOCK = 5'h0b;
  localparam logic [4:0] IDX_COMB_THRESH = 5'h0c;
  localparam logic [4:0] IDX_MOTION_SHIFT = 5'h0e;
  localparam logic [4:0] IDX_DEBUG = 5'h10;
  localparam logic [4:0] IDX_CADENCE_CFG = 5'h11;

  localparam logic [7:0] RST_PD_LOCK = 8'h06;
  localparam logic [7:0] RST_PD_UNLOCK = 8'h04;
  localparam logic [7:0] RST_DIFF_THRESH = 8'h10;
  localparam logic [7:0] RST_LINE_RATIO = 8'h04;
  localparam logic [7:0] RST_NOISE_SHIFT = 8'h05;
  localparam logic [3:0] RST_PAIR_LOCK = 4'h6;
  localparam logic [3:0] RST_PAIR_UNLOCK = 4'h4;
  localparam logic [7:0] RST_COMB_THRESH = 8'h10;
  localparam logic [7:0] RST_MOTION_SHIFT = 8'h00;
  localparam logic [2:0] RST_DEBUG = 3'h0;
  localparam logic RST_CADENCE_ON = 1'b1;

  localparam int unsigned DBG_VISUALIZE = 0;
  localparam int unsigned DBG_BOB_ONLY = 1;
  localparam int unsigned DBG_WEAVE_ONLY = 2;
  localparam logic [2:0] PULLDOWN_PERIOD_LAST = 3'h4;
  localparam logic [7:0] PINK_CHROMA = 8'hff;

  typedef enum logic [0:0] {
    LOCK_IDLE = 1'b0,
    LOCK_HELD = 1'b1
  } lock_state_type;
endpackage

// ---- design/line_classifier.sv ----
/*
  Per-line scoring: scales raw line differences and compares the 3:2 and
  2:2 detector scores against their thresholds. Purely combinational.
  Assumes the caller registers the hit flags where timing needs it.
*/
`timescale 1ns/1ps
module line_classifier (
  input wire logic [15:0] diff_raw,
  input wire logic [7:0] comb_score,
  input wire logic [7:0] motion_shift,
  input wire logic [7:0] noise_shift,
  input wire logic [7:0] diff_thresh,
  input wire logic [7:0] comb_thresh,
  output logic diff_hit,
  output logic comb_hit
);
  logic [15:0] scaled;
  logic [15:0] denoised;
  logic [7:0] score;

  always_comb begin
    scaled = diff_raw >> motion_shift;
    denoised = scaled >> noise_shift;
    // Saturate so a large difference never wraps below the threshold
    score = (denoised[15:8] != 8'h00) ? 8'hff : denoised[7:0];
    diff_hit = score >= diff_thresh;
    comb_hit = comb_score >= comb_thresh;
  end
endmodule // line_classifier

// ---- verif/ahb_host_model.sv ----
/*
  Host software model: AHB-Lite master doing single word transfers.
  Assumes hready is the bank's hreadyout; waits on it without a bound.
*/
`timescale 1ns/1ps
module ahb_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Byte address is the register index times four
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {25'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask
endmodule // ahb_host_model

// ---- verif/cadence_motion_tuning_regs_props.sv ----
/*
  Port checker for the tuning register bank.
  Assumes one clock, hresetn async active low; bound below.
*/
`timescale 1ns/1ps
module cadence_motion_tuning_regs_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic field_start,
  input wire logic pixel_valid,
  input wire logic out_valid,
  input wire logic [7:0] out_y,
  input wire logic [7:0] out_cr,
  input wire logic pulldown_locked,
  input wire logic pair_locked,
  input wire logic running
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_narrow_read_bits: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pixel_passes: assert property (pixel_valid && running && !field_start |=> out_valid)
    else $error("pixel lost while running");
  a_idle_holds_out: assert property (!pixel_valid |=> !out_valid && $stable(out_y) && $stable(out_cr))
    else $error("output moved without a pixel");
  a_run_at_field: assert property (!field_start |=> $stable(running))
    else $error("run state moved between fields");
  a_stop_blocks_pixels: assert property ((!running ##1 !running) |-> !out_valid)
    else $error("pixel output while halted");
  a_pd_lock_field: assert property ($rose(pulldown_locked) |-> $past(field_start))
    else $error("3:2 lock rose off a field boundary");
  a_pair_lock_field: assert property ($rose(pair_locked) |-> $past(field_start))
    else $error("2:2 lock rose off a field boundary");
  c_pair_lock: cover property ($rose(pair_locked));
  c_pixel_out: cover property (out_valid);
  c_halt: cover property ($fell(running));
  c_pd_lock: cover property ($rose(pulldown_locked));
endmodule // cadence_motion_tuning_regs_props

bind cadence_motion_tuning_regs cadence_motion_tuning_regs_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .field_start(field_start), .pixel_valid(pixel_valid), .out_valid(out_valid),
  .out_y(out_y), .out_cr(out_cr), .pulldown_locked(pulldown_locked),
  .pair_locked(pair_locked), .running(running)
);

// ---- verif/testbench.sv ----
/*
  Self-checking bench for the tuning register bank.
  Assumes 125 MHz hclk; host model drives the bus, bench the video side.
*/
`timescale 1ns/1ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, field_start, line_valid;
  logic pixel_valid, out_valid, out_weave, pulldown_locked, pair_locked, running;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [10:0] field_lines;
  logic [15:0] line_diff_raw, pixel_sad_raw;
  logic [7:0] line_comb_score, pixel_y, out_y, out_cb, out_cr;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [2:0] dbg_t[5] = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h6};
  logic [15:0] sad_t[5] = '{16'h0400, 16'h0, 16'h0, 16'h0400, 16'h0400};
  logic weave_t[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  cadence_motion_tuning_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .field_start(field_start), .field_lines(field_lines), .line_valid(line_valid),
    .line_diff_raw(line_diff_raw), .line_comb_score(line_comb_score),
    .pixel_valid(pixel_valid), .pixel_sad_raw(pixel_sad_raw), .pixel_y(pixel_y),
    .pixel_cb(8'h80), .pixel_cr(8'h80), .out_valid(out_valid), .out_y(out_y),
    .out_cb(out_cb), .out_cr(out_cr), .out_weave(out_weave),
    .pulldown_locked(pulldown_locked), .pair_locked(pair_locked), .running(running));
  ahb_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Cuts a hang short well past the expected few hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, idx, d, rd);
    #1;
  endtask
  task automatic rchk(input string what, input logic [4:0] idx, input logic [31:0] exp);
    u_host.xfer(1'b0, idx, 32'h0, rd);
    check(what, rd, exp);
  endtask
  task automatic pulse_field();
    @(posedge hclk);
    field_start <= 1'b1;
    @(posedge hclk);
    field_start <= 1'b0;
    #1;
  endtask
  // Four lines, then the field boundary that closes them
  task automatic field4(input logic [63:0] diffs, input logic [31:0] combs);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      line_valid <= 1'b1;
      line_diff_raw <= diffs[63-16*i -: 16];
      line_comb_score <= combs[31-8*i -: 8];
      @(posedge hclk);
      line_valid <= 1'b0;
    end
    pulse_field();
  endtask
  task automatic pix(input logic [15:0] sad);
    @(posedge hclk);
    pixel_valid <= 1'b1;
    pixel_sad_raw <= sad;
    @(posedge hclk);
    pixel_valid <= 1'b0;
    #1;
  endtask

  task automatic t_reset_map();
    wr(5'h0d, 32'hffffffff);
    wr(5'h0f, 32'hffffffff);
    rchk("pd lock", cadence_tuning_pkg::IDX_PD_LOCK, 32'h6);
    rchk("pd unlock", cadence_tuning_pkg::IDX_PD_UNLOCK, 32'h4);
    rchk("diff thresh", cadence_tuning_pkg::IDX_DIFF_THRESH, 32'h10);
    rchk("line ratio", cadence_tuning_pkg::IDX_LINE_RATIO, 32'h4);
    rchk("noise shift", cadence_tuning_pkg::IDX_NOISE_SHIFT, 32'h5);
    rchk("pair lock", cadence_tuning_pkg::IDX_PAIR_LOCK, 32'h6);
    rchk("pair unlock", cadence_tuning_pkg::IDX_PAIR_UNLOCK, 32'h4);
    rchk("comb thresh", cadence_tuning_pkg::IDX_COMB_THRESH, 32'h10);
    rchk("motion shift", cadence_tuning_pkg::IDX_MOTION_SHIFT, 32'h0);
    rchk("debug", cadence_tuning_pkg::IDX_DEBUG, 32'h0);
    rchk("unused 13", 5'h0d, 32'h0);
    rchk("unused 15", 5'h0f, 32'h0);
    $display("test reset_map done");
  endtask
  // Score is raw >> noise shift (5); 512 gives 16, exactly the threshold
  task automatic t_diff_count();
    wr(cadence_tuning_pkg::IDX_CONTROL, 32'h1);
    pulse_field();
    check("running", running, 1'b1);
    field4({16'd512, 16'd511, 16'd1023, 16'h0}, 32'h0);
    rchk("diff count", cadence_tuning_pkg::IDX_DIFF_COUNT, 32'h2);
    wr(cadence_tuning_pkg::IDX_MOTION_SHIFT, 32'h1);
    field4({16'd1024, 16'd1023, 16'hffff, 16'h0}, 32'h0);
    rchk("shifted count", cadence_tuning_pkg::IDX_DIFF_COUNT, 32'h2);
    rchk("field poll", cadence_tuning_pkg::IDX_DIFF_COUNT, 32'h2);
    $display("test diff_count done");
  endtask
  // Needed comb lines = 4 >> 1 = 2; comb field A has two hits, B none
  task automatic t_pair_lock();
    wr(cadence_tuning_pkg::IDX_LINE_RATIO, 32'h1);
    wr(cadence_tuning_pkg::IDX_PAIR_LOCK, 32'h2);
    wr(cadence_tuning_pkg::IDX_PAIR_UNLOCK, 32'h1);
    field4(64'h0, 32'h10100000);
    field4(64'h0, 32'h0f0f0f0f);
    check("lock after one", pair_locked, 1'b0);
    field4(64'h0, 32'h10100000);
    check("lock after two", pair_locked, 1'b1);
    field4(64'h0, 32'h10100000);
    check("held at unlock", pair_locked, 1'b1);
    field4(64'h0, 32'h10100000);
    check("dropped", pair_locked, 1'b0);
    field4(64'h0, 32'h0f0f0f0f);
    field4(64'h0, 32'h10100000);
    check("relocked", pair_locked, 1'b1);
    // 3:2 film: four changed fields, a repeat on the fifth, one more
    wr(cadence_tuning_pkg::IDX_LINE_RATIO, 32'h0);
    for (int i = 0; i < 6; i++) begin
      field4((i == 4) ? 64'h0 : 64'hffff_0000_0000_0000, 32'h0);
      if (i == 4) begin
        check("pd lock at five", pulldown_locked, 1'b0);
      end
    end
    check("pd lock at six", pulldown_locked, 1'b1);
    wr(cadence_tuning_pkg::IDX_CADENCE_CFG, 32'h0);
    @(posedge hclk);
    #1;
    check("cfg off", pair_locked | pulldown_locked, 1'b0);
    field4(64'h0, 32'h0f0f0f0f);
    field4(64'h0, 32'h10100000);
    check("ignored", pair_locked | pulldown_locked, 1'b0);
    $display("test pair_lock done");
  endtask
  // Motion level = sad >> 1 here; zero motion means weave
  task automatic t_debug();
    for (int i = 0; i < 5; i++) begin
      wr(cadence_tuning_pkg::IDX_DEBUG, {29'h0, dbg_t[i]});
      pix(sad_t[i]);
      check("weave", out_weave, weave_t[i]);
    end
    wr(cadence_tuning_pkg::IDX_DEBUG, 32'h1);
    pix(16'h0040);
    check("valid", out_valid, 1'b1);
    check("pink", {out_y, out_cb, out_cr}, 24'h20ffff);
    pix(16'h0);
    check("still", {out_y, out_cb, out_cr}, {pixel_y, 16'h8080});
    $display("test debug done");
  endtask
  task automatic t_halt();
    wr(cadence_tuning_pkg::IDX_CONTROL, 32'h0);
    check("until boundary", running, 1'b1);
    pulse_field();
    check("halted", running, 1'b0);
    rchk("status", cadence_tuning_pkg::IDX_STATUS, 32'h0);
    pix(16'h0);
    check("no output", out_valid, 1'b0);
    $display("test halt done");
  endtask

  initial begin
    hresetn = 1'b0;
    field_start = 1'b0;
    field_lines = 11'd4;
    line_valid = 1'b0;
    line_diff_raw = 16'h0;
    line_comb_score = 8'h0;
    pixel_valid = 1'b0;
    pixel_sad_raw = 16'h0;
    pixel_y = 8'h5a;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_map();
    t_diff_count();
    t_pair_lock();
    t_debug();
    t_halt();
    tally_and_finish();
  end
endmodule // testbench
